/* logic/link_pkg.sv */
`default_nettype none
package link_pkg;

	// Link operating mode, fixed by board straps outside this block.
	typedef enum logic [1:0] {
		MODE_AC97_PRIMARY,
		MODE_AC97_SECONDARY,
		MODE_DSP
	} linkMode_type;

	// Pin bundle towards the controller; an enable low means driven.
	typedef struct packed {
		logic bitClk;
		logic bitClkOe;
		logic frameSync;
		logic frameSyncOe;
		logic data;
		logic dataOe;
	} linkPins_type;

	// Core clock period and printed link times, all in picoseconds.
	localparam int CORE_PERIOD_PS    = 5000;
	localparam int RST2CLK_MIN_PS    = 162800;
	localparam int SYNC2CLK_MIN_PS   = 162800;
	localparam int S2_PDOWN_MIN_PS   = 2000;
	localparam int S2_PDOWN_MAX_PS   = 1000000;
	localparam int OFF_MAX_PS        = 25000;
	localparam int AC97_HALF_PS      = 40690;
	localparam int DSP_HALF_PS       = 122070;

	// Least times round up, longest times and half periods round down.
	localparam int RST2CLK_CYC  = (RST2CLK_MIN_PS + CORE_PERIOD_PS - 1)
		/ CORE_PERIOD_PS;
	localparam int SYNC2CLK_CYC = (SYNC2CLK_MIN_PS + CORE_PERIOD_PS - 1)
		/ CORE_PERIOD_PS;
	localparam int S2_PDOWN_MIN_CYC = (S2_PDOWN_MIN_PS + CORE_PERIOD_PS - 1)
		/ CORE_PERIOD_PS;
	localparam int S2_PDOWN_MAX_CYC = S2_PDOWN_MAX_PS / CORE_PERIOD_PS;
	localparam int OFF_MAX_CYC      = OFF_MAX_PS / CORE_PERIOD_PS;
	localparam int AC97_HALF_CYC    = AC97_HALF_PS / CORE_PERIOD_PS;
	localparam int DSP_HALF_CYC     = DSP_HALF_PS / CORE_PERIOD_PS;

	// Frame layout in bit clocks: tag slot, then 20-bit slots.
	localparam int TAG_BITS        = 16;
	localparam int SLOT_BITS       = 20;
	localparam int SLOT2_END_BIT   = TAG_BITS + 2 * SLOT_BITS - 1;
	localparam int AC97_FRAME_BITS = 256;
	localparam int DSP_FRAME_BITS  = 512;

	localparam int CNT_W   = 10;
	localparam int WAIT_W  = 8;

endpackage
`default_nettype wire

/* logic/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wrPtr_r;
	logic [AW:0]      rdPtr_r;
	logic             push;
	logic             pop;

	// Full when the pointers differ only in the wrap bit.
	assign inReady  = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
	assign outValid = wrPtr_r != rdPtr_r;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = mem_r[rdPtr_r[AW-1:0]];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wrPtr_r[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

/* logic/codec_link_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Bit clock starts no sooner than 162.8 ns after reset release.
// - Bit clock restarts no sooner than 162.8 ns after warm sync falls.
// - With power-down bit set, clock and data go low 2-1000 ns after slot 2.
// - Tester mode releases link outputs within 25 ns of reset rising.
// - Bit clock driven in AC97 primary and DSP modes, input in secondary.
// - Frame sync driven in DSP mode, input in all AC97 modes.
// - Reset pin low selects configured power-down depth, not a logic reset.
module codec_link_sequencer #(
	parameter int WORD_WIDTH = 16,
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Configuration
	input  wire link_pkg::linkMode_type linkMode,
	input  wire logic [1:0]            powerDepth,
	input  wire logic                  linkPowerDownBit,
	input  wire logic                  testerOutputReleaseMode,
	// Transmit stream
	input  wire logic                  txValid,
	output logic                       txReady,
	input  wire logic [WORD_WIDTH-1:0] txData,
	// Link pins
	input  wire logic                  resetPinN,
	input  wire logic                  bitClkIn,
	input  wire logic                  frameSyncIn,
	output link_pkg::linkPins_type     linkPins,
	// Status
	output logic [1:0]                 powerLevel,
	output logic                       linkActive
);
	typedef enum logic [2:0] {
		ST_POWER_DOWN,
		ST_START_WAIT,
		ST_RUNNING,
		ST_SLEEP,
		ST_WARM_WAIT,
		ST_RELEASED
	} state_type;

	localparam logic [link_pkg::WAIT_W-1:0] RST2CLK_CNT =
		link_pkg::WAIT_W'(link_pkg::RST2CLK_CYC);
	localparam logic [link_pkg::WAIT_W-1:0] SYNC2CLK_CNT =
		link_pkg::WAIT_W'(link_pkg::SYNC2CLK_CYC);
	localparam logic [link_pkg::CNT_W-1:0] SLOT2_END =
		link_pkg::CNT_W'(link_pkg::SLOT2_END_BIT);
	localparam logic [link_pkg::CNT_W-1:0] AC97_LAST =
		link_pkg::CNT_W'(link_pkg::AC97_FRAME_BITS - 1);
	localparam logic [link_pkg::CNT_W-1:0] DSP_LAST =
		link_pkg::CNT_W'(link_pkg::DSP_FRAME_BITS - 1);
	localparam logic [link_pkg::WAIT_W-1:0] AC97_HALF =
		link_pkg::WAIT_W'(link_pkg::AC97_HALF_CYC - 1);
	localparam logic [link_pkg::WAIT_W-1:0] DSP_HALF =
		link_pkg::WAIT_W'(link_pkg::DSP_HALF_CYC - 1);
	localparam int BW = $clog2(WORD_WIDTH);

	state_type                     state_r;
	logic [2:0]                    meta_r;
	logic [2:0]                    sync_r;
	logic                          pinPrev_r;
	logic                          clkPrev_r;
	logic                          fsPrev_r;
	logic [link_pkg::WAIT_W-1:0]   wait_r;
	logic [link_pkg::WAIT_W-1:0]   half_r;
	logic                          genClk_r;
	logic [link_pkg::CNT_W-1:0]    bitCnt_r;
	logic [WORD_WIDTH-1:0]         shift_r;
	logic [BW-1:0]                 wordBit_r;
	logic                          dataBit_r;
	logic                          syncOut_r;
	logic [1:0]                    powerLevel_r;
	logic                          pinN;
	logic                          drivesClk;
	logic                          rise;
	logic                          fall;
	logic                          frameStart;
	logic                          fifoValid;
	logic                          fifoPop;
	logic [WORD_WIDTH-1:0]         fifoData;

	function automatic logic ownsClock(input link_pkg::linkMode_type m);
		return m != link_pkg::MODE_AC97_SECONDARY;
	endfunction

	// Pins pass two flops; only the second stage feeds any logic.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
		end else begin
			meta_r <= {frameSyncIn, bitClkIn, resetPinN};
			sync_r <= meta_r;
		end
	end

	assign pinN      = sync_r[0];
	assign drivesClk = ownsClock(linkMode);

	// Bit clock edges come from our divider or from the sampled pin.
	assign rise = (state_r == ST_RUNNING) && (drivesClk
		? (!genClk_r && half_r == '0)
		: (sync_r[1] && !clkPrev_r));
	assign fall = (state_r == ST_RUNNING) && (drivesClk
		? (genClk_r && half_r == '0)
		: (!sync_r[1] && clkPrev_r));

	// In AC97 modes the controller frames; in DSP mode we do.
	assign frameStart = (linkMode == link_pkg::MODE_DSP)
		? (rise && bitCnt_r == DSP_LAST)
		: (sync_r[2] && !fsPrev_r);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinPrev_r <= 1'b0;
			clkPrev_r <= 1'b0;
			fsPrev_r  <= 1'b0;
		end else begin
			pinPrev_r <= pinN;
			clkPrev_r <= sync_r[1];
			fsPrev_r  <= sync_r[2];
		end
	end

	// Sequencer; the wait counter only runs in the two wait states.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_POWER_DOWN;
			wait_r  <= '0;
		end else if (!pinN) begin
			state_r <= ST_POWER_DOWN;
			wait_r  <= '0;
		end else begin
			case (state_r)
			ST_POWER_DOWN: begin
				if (!pinPrev_r && testerOutputReleaseMode) begin
					state_r <= ST_RELEASED;
				end else begin
					state_r <= ST_START_WAIT;
					wait_r  <= RST2CLK_CNT;
				end
			end
			ST_START_WAIT: begin
				if (wait_r == '0) begin
					state_r <= ST_RUNNING;
				end else begin
					wait_r <= wait_r - 1'b1;
				end
			end
			ST_RUNNING: begin
				if (fall && bitCnt_r == SLOT2_END && linkPowerDownBit) begin
					state_r <= ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (linkMode != link_pkg::MODE_DSP && fsPrev_r && !sync_r[2]) begin
					state_r <= ST_WARM_WAIT;
					wait_r  <= SYNC2CLK_CNT;
				end
			end
			ST_WARM_WAIT: begin
				if (wait_r == '0) begin
					state_r <= ST_RUNNING;
				end else begin
					wait_r <= wait_r - 1'b1;
				end
			end
			ST_RELEASED: begin
				state_r <= ST_RELEASED;
			end
			default: begin
				state_r <= ST_POWER_DOWN;
			end
			endcase
		end
	end

	// Divider for the clock we own; parked low outside the running state.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			genClk_r <= 1'b0;
			half_r   <= '0;
		end else if (state_r != ST_RUNNING || !drivesClk || !pinN) begin
			// Parking on the pin too keeps a clock edge from escaping
			// in the cycle that the pin forces power-down.
			genClk_r <= 1'b0;
			half_r   <= (linkMode == link_pkg::MODE_DSP) ? DSP_HALF : AC97_HALF;
		end else if (half_r == '0) begin
			genClk_r <= !genClk_r;
			half_r   <= (linkMode == link_pkg::MODE_DSP) ? DSP_HALF : AC97_HALF;
		end else begin
			half_r <= half_r - 1'b1;
		end
	end

	// Bit position within the frame, advanced on falling edges.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bitCnt_r <= '0;
		end else if (state_r != ST_RUNNING) begin
			bitCnt_r <= (linkMode == link_pkg::MODE_DSP) ? DSP_LAST : AC97_LAST;
		end else if (frameStart) begin
			bitCnt_r <= '0;
		end else if (fall && bitCnt_r == ((linkMode == link_pkg::MODE_DSP)
			? DSP_LAST : AC97_LAST)) begin
			// Without a sync the frame runs free, so slot 2 still ends.
			bitCnt_r <= '0;
		end else if (fall) begin
			bitCnt_r <= bitCnt_r + 1'b1;
		end
	end

	// DSP frame sync is high for the first bit of each frame.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			syncOut_r <= 1'b0;
		end else if (state_r != ST_RUNNING) begin
			syncOut_r <= 1'b0;
		end else if (rise) begin
			syncOut_r <= frameStart;
		end
	end

	// A word is taken at each word boundary; an empty FIFO sends zeros
	// rather than stalling the frame, which the far end cannot wait for.
	assign fifoPop = rise && wordBit_r == '0;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_r   <= '0;
			wordBit_r <= '0;
			dataBit_r <= 1'b0;
		end else if (state_r != ST_RUNNING) begin
			wordBit_r <= '0;
			dataBit_r <= 1'b0;
		end else if (rise) begin
			if (wordBit_r == '0) begin
				shift_r   <= fifoValid ? fifoData << 1 : '0;
				dataBit_r <= fifoValid && fifoData[WORD_WIDTH-1];
			end else begin
				shift_r   <= shift_r << 1;
				dataBit_r <= shift_r[WORD_WIDTH-1];
			end
			wordBit_r <= (wordBit_r == BW'(WORD_WIDTH - 1)) ? '0
				: wordBit_r + 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			powerLevel_r <= 2'h0;
		end else if (!pinN) begin
			powerLevel_r <= powerDepth;
		end else begin
			powerLevel_r <= 2'h0;
		end
	end

	word_fifo #(
		.WIDTH (WORD_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) txFifo (
		.core_clk (core_clk),
		.rst      (rst),
		.inValid  (txValid),
		.inReady  (txReady),
		.inData   (txData),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);

	// Released state floats every link output for the tester.
	always_comb begin
		linkPins.bitClk      = genClk_r;
		linkPins.bitClkOe    = !(drivesClk && state_r != ST_RELEASED);
		linkPins.frameSync   = syncOut_r;
		linkPins.frameSyncOe = !(linkMode == link_pkg::MODE_DSP
			&& state_r != ST_RELEASED);
		linkPins.data        = dataBit_r;
		linkPins.dataOe      = state_r == ST_RELEASED;
	end

	assign powerLevel = powerLevel_r;
	assign linkActive = state_r == ST_RUNNING;

endmodule
`default_nettype wire

/* verification/link_seq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module link_seq_assertions (
	// Clock and reset
	input wire logic                   core_clk,
	input wire logic                   rst,
	// Configuration
	input wire link_pkg::linkMode_type linkMode,
	input wire logic [1:0]             powerDepth,
	input wire logic                   linkPowerDownBit,
	input wire logic                   testerOutputReleaseMode,
	// Pins and status
	input wire logic                   resetPinN,
	input wire logic                   frameSyncIn,
	input wire link_pkg::linkPins_type linkPins,
	input wire logic [1:0]             powerLevel,
	input wire logic                   linkActive
);
	logic [5:0]  upCnt_r;
	logic [5:0]  syncCnt_r;
	logic [12:0] pdCnt_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Ages saturate so that long idle stretches cannot wrap them.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			upCnt_r <= 6'h00;
		else if (!resetPinN)
			upCnt_r <= 6'h00;
		else if (upCnt_r != 6'h3F)
			upCnt_r <= upCnt_r + 6'h01;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			syncCnt_r <= 6'h00;
		else if (frameSyncIn)
			syncCnt_r <= 6'h00;
		else if (syncCnt_r != 6'h3F)
			syncCnt_r <= syncCnt_r + 6'h01;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			pdCnt_r <= 13'h0000;
		else if (!(linkActive && linkPowerDownBit))
			pdCnt_r <= 13'h0000;
		else if (pdCnt_r != 13'h1FFF)
			pdCnt_r <= pdCnt_r + 13'h0001;
	end

	rst2clk_a: assert property ($rose(linkPins.bitClk) |-> upCnt_r >= 6'h21)
		else $error("bit clock started too soon after reset pin");
	warm2clk_a: assert property ($rose(linkPins.bitClk) &&
		linkMode != link_pkg::MODE_DSP |-> syncCnt_r >= 6'h21)
		else $error("bit clock restarted too soon after sync");
	// One frame of 4096 cycles plus a 304 cycle exit allowance.
	pd_bound_a: assert property (linkMode == link_pkg::MODE_AC97_PRIMARY
		|-> pdCnt_r < 13'h1130)
		else $error("link power-down not taken in time");
	sleep_low_a: assert property ($fell(linkActive) && resetPinN &&
		!testerOutputReleaseMode |=> !linkPins.bitClk && !linkPins.data)
		else $error("clock or data not low on sleep entry");
	clk_gate_a: assert property ($rose(linkPins.bitClk) |-> linkActive)
		else $error("bit clock moved while link stopped");
	tester_off_a: assert property ($rose(resetPinN) && testerOutputReleaseMode
		|-> ##[1:4] (linkPins.bitClkOe && linkPins.frameSyncOe && linkPins.dataOe))
		else $error("outputs not released in tester mode");
	clk_dir_a: assert property (linkMode == link_pkg::MODE_AC97_SECONDARY
		|-> linkPins.bitClkOe)
		else $error("bit clock driven in secondary mode");
	sync_dir_a: assert property (linkMode != link_pkg::MODE_DSP |->
		linkPins.frameSyncOe)
		else $error("sync driven in a controller-sync mode");
	dsp_drive_a: assert property (linkMode == link_pkg::MODE_DSP &&
		linkActive |-> !linkPins.bitClkOe && !linkPins.frameSyncOe)
		else $error("clock or sync not driven in DSP mode");
	depth_show_a: assert property (!resetPinN [*4] |->
		powerLevel == $past(powerDepth))
		else $error("power level does not follow depth");

	cover property ($fell(linkActive) && resetPinN);
	cover property ($rose(resetPinN) && testerOutputReleaseMode);
	cover property ($rose(linkPins.frameSync));
endmodule
bind codec_link_sequencer link_seq_assertions chk_u (.core_clk, .rst,
	.linkMode, .powerDepth, .linkPowerDownBit, .testerOutputReleaseMode,
	.resetPinN, .frameSyncIn, .linkPins, .powerLevel, .linkActive);
`default_nettype wire

/* verification/link_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_model (
	// Clock and bench control
	input  wire logic                   core_clk,
	input  wire logic                   runClk,
	// Pins
	input  wire link_pkg::linkPins_type linkPins,
	output logic                        resetPinN,
	output logic                        bitClkIn,
	output logic                        frameSyncIn,
	output logic [15:0]                 rxShift
);
	logic ctrlClk;
	logic ctrlSync;

	initial begin
		resetPinN = 1'b0;
		ctrlClk = 1'b0;
		ctrlSync = 1'b0;
		rxShift = 16'h0000;
	end
	// Each shared pin shows whichever side has its driver on.
	assign bitClkIn = linkPins.bitClkOe ? ctrlClk : linkPins.bitClk;
	assign frameSyncIn = linkPins.frameSyncOe ? ctrlSync : linkPins.frameSync;
	// Our clock stands still unless asked to run.
	always begin
		#40;
		ctrlClk = runClk ? ~ctrlClk : 1'b0;
	end
	always @(negedge bitClkIn) rxShift <= {rxShift[14:0], linkPins.data};

	task automatic coldReset(input int lowCyc);
		@(posedge core_clk) #1 resetPinN = 1'b0;
		repeat (lowCyc) @(posedge core_clk);
		#1 resetPinN = 1'b1;
	endtask
	task automatic warmReset();
		@(posedge core_clk) #1 ctrlSync = 1'b1;
		repeat (260) @(posedge core_clk);
		#1 ctrlSync = 1'b0;
	endtask
endmodule
`default_nettype wire

/* verification/tb_codec_link_reset_power_timing.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin \
	n_mismatch++; $display("wrong value %s exp %0h seen %0h", nm, ex, sn); \
	end end
`define WAITF(c, lim) begin int w; w = 0; \
	while (!(c) && w < lim) begin @(posedge core_clk); #1 w++; end end
module tb_codec_link_reset_power_timing;
	logic                   core_clk;
	logic                   rst;
	link_pkg::linkMode_type linkMode;
	logic [1:0]             powerDepth;
	logic                   linkPowerDownBit;
	logic                   testerOutputReleaseMode;
	logic                   txValid;
	logic                   txReady;
	logic [15:0]            txData;
	logic                   resetPinN;
	logic                   bitClkIn;
	logic                   frameSyncIn;
	link_pkg::linkPins_type linkPins;
	logic [1:0]             powerLevel;
	logic                   linkActive;
	logic                   runClk;
	logic [15:0]            rxShift;
	int                     n_mismatch;
	int                     n_checks;
	int                     cycles;

	codec_link_sequencer dut_u (.core_clk, .rst, .linkMode, .powerDepth,
		.linkPowerDownBit, .testerOutputReleaseMode, .txValid, .txReady,
		.txData, .resetPinN, .bitClkIn, .frameSyncIn, .linkPins,
		.powerLevel, .linkActive);
	link_ctrl_model ctl_u (.core_clk, .runClk, .linkPins, .resetPinN,
		.bitClkIn, .frameSyncIn, .rxShift);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic measure(output int k);
		k = 0;
		while (linkPins.bitClk !== 1'b1 && k < 300) begin
			@(posedge core_clk) #1;
			k++;
		end
	endtask
	// Fill while the pin holds the link down, then drain after start-up.
	task automatic t_fill();
		int n;
		int k;
		n = 0;
		`CHK("depth", 2'h2, powerLevel)
		txValid = 1'b1;
		txData = 16'hA500;
		for (int i = 0; i < 40; i++) begin
			#3;
			if (txReady === 1'b1) n++;
			@(posedge core_clk) #1 txData = 16'hA500 + n[15:0];
		end
		txValid = 1'b0;
		`CHK("accepted", 32, n)
		ctl_u.coldReset(200);
		measure(k);
		`CHK("cold start", 1'b1, k >= 33 && k < 300)
		`CHK("run level", 2'h0, powerLevel)
		`WAITF(rxShift === 16'hA500, 3000)
		`CHK("word", 16'hA500, rxShift)
		for (int i = 1; i < 32; i++) begin
			repeat (16) @(negedge bitClkIn);
			#1 `CHK("word", 16'hA500 + i[15:0], rxShift)
		end
		`CHK("ready", 1'b1, txReady)
	endtask
	task automatic t_sleep();
		int k;
		linkPowerDownBit = 1'b1;
		`WAITF(linkActive === 1'b0, 5000)
		`CHK("sleep", 2'h0, {linkPins.bitClk, linkPins.data})
		linkPowerDownBit = 1'b0;
		repeat (300) @(posedge core_clk);
		#1 `CHK("asleep", 1'b0, linkPins.bitClk | linkActive)
		ctl_u.warmReset();
		measure(k);
		`CHK("warm start", 1'b1, k >= 33 && k < 300)
	endtask
	task automatic t_tester();
		testerOutputReleaseMode = 1'b1;
		ctl_u.coldReset(200);
		repeat (4) @(posedge core_clk);
		#1 `CHK("release", 3'h7,
			{linkPins.bitClkOe, linkPins.frameSyncOe, linkPins.dataOe})
		testerOutputReleaseMode = 1'b0;
	endtask
	task automatic t_modes();
		link_pkg::linkMode_type m;
		for (int i = 0; i < 2; i++) begin
			m = i ? link_pkg::MODE_DSP : link_pkg::MODE_AC97_SECONDARY;
			rst = 1'b1;
			linkMode = m;
			runClk = !i;
			@(posedge core_clk) #1 rst = 1'b0;
			ctl_u.coldReset(200);
			repeat (200) @(posedge core_clk);
			#1 `CHK("clk dir", !i, linkPins.bitClkOe)
			`CHK("sync dir", !i, linkPins.frameSyncOe)
		end
		`WAITF(linkPins.frameSync === 1'b1, 26000)
		`CHK("dsp sync", 1'b1, linkPins.frameSync)
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		cycles = 0;
		rst = 1'b1;
		linkMode = link_pkg::MODE_AC97_PRIMARY;
		powerDepth = 2'h2;
		linkPowerDownBit = 1'b0;
		testerOutputReleaseMode = 1'b0;
		txValid = 1'b0;
		txData = 16'h0000;
		runClk = 1'b0;
		repeat (3) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (5) @(posedge core_clk);
		#1 t_fill();
		t_sleep();
		t_tester();
		t_modes();
		report_and_stop();
	end
endmodule
`default_nettype wire
